// ---- include/bst_pkg.sv ----
`default_nettype none
package bst_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] WAIT_TIMES_ADDR = 8'h28; // bemf_wait_times
  localparam logic [7:0] OD_SAMPLE_ADDR = 8'h29; // overdrive_and_sample_timing
  localparam logic [7:0] WAIT_TIMES_RESET = 8'h11;
  localparam logic [7:0] OD_SAMPLE_RESET = 8'h0C;
  localparam int SETTLE_MSB = 7;
  localparam int SETTLE_LSB = 4;
  localparam int DISCH_MSB = 3;
  localparam int DISCH_LSB = 0;
  localparam int RSVD_MSB = 7;
  localparam int RSVD_LSB = 6;
  localparam int CLAMP_MSB = 5;
  localparam int CLAMP_LSB = 4;
  localparam int SAMPLE_MSB = 3;
  localparam int SAMPLE_LSB = 2;
  localparam int WIN_MSB = 1;
  localparam int WIN_LSB = 0;
  localparam logic [1:0] CLAMP_AUTO = 2'h0;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 250;
  localparam int US_CYCLES = CLK_MHZ; // cycles per microsecond
  localparam int MS_CYCLES = CLK_MHZ * 1000;
  localparam int CLAMP1_MS = 25;
  localparam int CLAMP2_MS = 50;
  localparam int CLAMP3_MS = 100;
  localparam int LRA_US [16] = '{15, 25, 50, 75, 90, 105, 120, 135,
                                 150, 165, 180, 195, 210, 235, 260, 285};
  localparam int ERM_US [4] = '{45, 75, 150, 225};
  localparam int WIN_US [4] = '{100, 200, 300, 390};
  localparam int CNT_W = 25; // holds 100 ms at 250 MHz
  localparam logic [CNT_W-1:0] CLAMP_CYC [4] = '{
    25'h000_0000,
    25'(CLAMP1_MS * MS_CYCLES),
    25'(CLAMP2_MS * MS_CYCLES),
    25'(CLAMP3_MS * MS_CYCLES)};
endpackage : bst_pkg
`default_nettype wire

// ---- hdl/bst_timing_regs.sv ----
// Functional notes
// - settle-wait field bits 7:4 of first register, read/write, resets to 1
// - resonant settle codes 0..15 map to 15..285 us table
// - eccentric settle codes 0..3 map to 45,75,150,225 us; others undefined
// - discharge-wait field bits 3:0 of first register, read/write, resets to 1
// - resonant discharge codes use same 15..285 us table
// - eccentric discharge codes 0..3 map to 45,75,150,225 us
// - overdrive clamp field bits 5:4, resets 0; 0 means unlimited
// - clamp codes 1,2,3 limit overdrive/braking to 25,50,100 ms
// - on clamp expiry drop to nominal clamp at once, no crossing wait
// - clamp setting ignored during calibration or diagnostics
// - calibration always uses automatic unclamped overdrive
// - sample-offset field bits 3:2, read/write, resets to 3
// - crossing window bits 1:0, reset 0, codes give 100,200,300,390 us
`default_nettype none
module bst_timing_regs #(
  parameter int CNT_W = bst_pkg::CNT_W
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port from the serial control block
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // actuator and sequencer context
  input wire logic ACT_IS_ERM,
  input wire logic CAL_ACTIVE,
  input wire logic DIAG_ACTIVE,
  input wire logic INTERVAL_START,
  input wire logic OVERDRIVE_ACTIVE,
  // timing outputs; settle, discharge and window in clock cycles
  output logic [CNT_W-1:0] SETTLE_CYC,
  output logic [CNT_W-1:0] DISCH_CYC,
  output logic [CNT_W-1:0] WINDOW_CYC,
  output logic [1:0] SAMPLE_OFFSET,
  output logic CODE_UNDEFINED,
  output logic CLAMP_TO_NOMINAL
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] wait_times;
    logic [7:0] od_sample;
    logic [7:0] rdata;
    logic [CNT_W-1:0] settle;
    logic [CNT_W-1:0] disch;
    logic [CNT_W-1:0] window;
    logic [1:0] sample;
    logic undef;
    logic [CNT_W-1:0] od_cnt;
    logic clamp;
  } bst_state_s;

  bst_state_s st_reg;
  bst_state_s st_next;

  initial begin
    if (CNT_W < 25) begin
      $error("CNT_W too narrow for the longest clamp period");
    end
  end

  // code to wait cycles for the selected actuator type
  function automatic logic [CNT_W-1:0] wait_cyc(input logic [3:0] code, input logic erm);
    logic [CNT_W-1:0] r;
    r = '0;
    if (erm) begin
      r = CNT_W'(bst_pkg::ERM_US[code[1:0]] * bst_pkg::US_CYCLES);
    end else begin
      r = CNT_W'(bst_pkg::LRA_US[code] * bst_pkg::US_CYCLES);
    end
    return r;
  endfunction : wait_cyc

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [1:0] eff_clamp;
    eff_clamp = '0;
    st_next = st_reg;
    // register writes
    if (REG_WR && REG_ADDR == bst_pkg::WAIT_TIMES_ADDR) begin
      st_next.wait_times = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == bst_pkg::OD_SAMPLE_ADDR) begin
      st_next.od_sample = REG_WDATA;
    end
    // readback, unmapped reads zero
    unique case (REG_ADDR)
      bst_pkg::WAIT_TIMES_ADDR: st_next.rdata = st_reg.wait_times;
      bst_pkg::OD_SAMPLE_ADDR: st_next.rdata = st_reg.od_sample;
      default: st_next.rdata = 8'h00;
    endcase
    // latch decoded timings at interval start only
    if (INTERVAL_START) begin
      st_next.settle = wait_cyc(st_reg.wait_times[bst_pkg::SETTLE_MSB:bst_pkg::SETTLE_LSB],
                                ACT_IS_ERM);
      st_next.disch = wait_cyc(st_reg.wait_times[bst_pkg::DISCH_MSB:bst_pkg::DISCH_LSB],
                               ACT_IS_ERM);
      st_next.window = CNT_W'(bst_pkg::WIN_US[st_reg.od_sample[bst_pkg::WIN_MSB:bst_pkg::WIN_LSB]]
                              * bst_pkg::US_CYCLES);
      st_next.sample = st_reg.od_sample[bst_pkg::SAMPLE_MSB:bst_pkg::SAMPLE_LSB];
      st_next.undef = ACT_IS_ERM &&
        (st_reg.wait_times[7:6] != 2'h0 || st_reg.wait_times[3:2] != 2'h0);
    end
    // overdrive clamp timer
    eff_clamp = st_reg.od_sample[bst_pkg::CLAMP_MSB:bst_pkg::CLAMP_LSB];
    if (CAL_ACTIVE || DIAG_ACTIVE) begin
      eff_clamp = bst_pkg::CLAMP_AUTO;
    end
    if (!OVERDRIVE_ACTIVE || eff_clamp == bst_pkg::CLAMP_AUTO) begin
      st_next.od_cnt = '0;
      st_next.clamp = 1'b0;
    end else if (st_reg.od_cnt + 1'b1 >= bst_pkg::CLAMP_CYC[eff_clamp]) begin
      st_next.clamp = 1'b1;
    end else begin
      st_next.od_cnt = st_reg.od_cnt + 1'b1;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.wait_times <= bst_pkg::WAIT_TIMES_RESET;
      st_reg.od_sample <= bst_pkg::OD_SAMPLE_RESET;
      st_reg.sample <= bst_pkg::OD_SAMPLE_RESET[bst_pkg::SAMPLE_MSB:bst_pkg::SAMPLE_LSB];
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign REG_RDATA = st_reg.rdata;
  assign SETTLE_CYC = st_reg.settle;
  assign DISCH_CYC = st_reg.disch;
  assign WINDOW_CYC = st_reg.window;
  assign SAMPLE_OFFSET = st_reg.sample;
  assign CODE_UNDEFINED = st_reg.undef;
  assign CLAMP_TO_NOMINAL = st_reg.clamp;

  // ************************************************************
  // checks
  // ************************************************************
  a_reset_values: assert property (@(posedge CLOCK) $past(RST) |->
    st_reg.wait_times == 8'h11 && st_reg.od_sample == 8'h0C)
    else $error("register reset values wrong");
  a_clamp_ignored: assert property (@(posedge CLOCK) disable iff (RST)
    (CAL_ACTIVE || DIAG_ACTIVE) |=> !CLAMP_TO_NOMINAL)
    else $error("clamp active during calibration or diagnostics");
  a_auto_unclamped: assert property (@(posedge CLOCK) disable iff (RST)
    (st_reg.od_sample[5:4] == 2'h0) |=> !CLAMP_TO_NOMINAL)
    else $error("clamp with automatic overdrive");
  a_clamp_drop: assert property (@(posedge CLOCK) disable iff (RST)
    !OVERDRIVE_ACTIVE |=> !CLAMP_TO_NOMINAL)
    else $error("clamp outlived overdrive");
  a_hold_between: assert property (@(posedge CLOCK) disable iff (RST)
    !INTERVAL_START |=> $stable(SETTLE_CYC) && $stable(DISCH_CYC))
    else $error("wait changed mid interval");
  a_lra_settle: assert property (@(posedge CLOCK) disable iff (RST)
    INTERVAL_START && !ACT_IS_ERM && st_reg.wait_times[7:4] == 4'h0 |=>
    SETTLE_CYC == 25'd3750)
    else $error("resonant settle code 0 wrong");
  a_erm_disch: assert property (@(posedge CLOCK) disable iff (RST)
    INTERVAL_START && ACT_IS_ERM && st_reg.wait_times[3:0] == 4'h3 |=>
    DISCH_CYC == 25'd56250)
    else $error("eccentric discharge code 3 wrong");
  a_window_max: assert property (@(posedge CLOCK) disable iff (RST)
    INTERVAL_START && st_reg.od_sample[1:0] == 2'h3 |=> WINDOW_CYC == 25'd97500)
    else $error("window code 3 wrong");
  a_clamp_time: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(CLAMP_TO_NOMINAL) && !$past(CAL_ACTIVE) && !$past(DIAG_ACTIVE) &&
    $past(st_reg.od_sample[5:4]) == 2'h1 |-> $past(st_reg.od_cnt) == 25'd6249999)
    else $error("clamp period 1 wrong");
endmodule : bst_timing_regs
`default_nettype wire

// ---- test/bst_host_model.sv ----
`default_nettype none
module bst_host_model (
  // clock
  input wire logic CLOCK,
  // register port toward the device
  output logic [7:0] REG_ADDR,
  output logic REG_WR,
  output logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle port at time zero
  initial begin
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_WDATA = 8'h00;
  end
  // one-cycle write strobe; stale data is scrambled once the strobe drops
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge CLOCK);
    #1;
    REG_ADDR = addr;
    REG_WDATA = data;
    REG_WR = 1'b1;
    @(posedge CLOCK);
    #1;
    REG_WR = 1'b0;
    REG_WDATA = ~data;
  endtask : wr
  // read data is registered one cycle behind the address
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge CLOCK);
    #1;
    REG_ADDR = addr;
    @(posedge CLOCK);
    #1;
    data = REG_RDATA;
  endtask : rd
endmodule : bst_host_model
`default_nettype wire

// ---- test/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CW = bst_pkg::CNT_W;
  localparam int US = bst_pkg::US_CYCLES;
  logic CLOCK, RST, wr, erm, cal, diag, start, od, undef, clamp;
  logic [7:0] addr, wdata, rdata, rd_v;
  logic [CW-1:0] settle, disch, window;
  logic [1:0] offs;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  bst_timing_regs #(.CNT_W(CW)) bst_timing_regs_i (.CLOCK(CLOCK), .RST(RST),
    .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .ACT_IS_ERM(erm), .CAL_ACTIVE(cal), .DIAG_ACTIVE(diag), .INTERVAL_START(start),
    .OVERDRIVE_ACTIVE(od), .SETTLE_CYC(settle), .DISCH_CYC(disch), .WINDOW_CYC(window),
    .SAMPLE_OFFSET(offs), .CODE_UNDEFINED(undef), .CLAMP_TO_NOMINAL(clamp));
  bst_host_model bst_host_model_i (.CLOCK(CLOCK), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RDATA(rdata));
  // 250 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #2 CLOCK = ~CLOCK;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results
  // one interval-start pulse, then let the latched decode settle
  task automatic pulse;
    @(posedge CLOCK);
    #1;
    start = 1'b1;
    @(posedge CLOCK);
    #1;
    start = 1'b0;
    @(posedge CLOCK);
    #1;
  endtask : pulse
  // cycle ceiling against a hang
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      results();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    RST = 1'b1;
    {erm, cal, diag, start, od} = 5'h00;
    repeat (4) @(posedge CLOCK);
    #1;
    RST = 1'b0;
    bst_host_model_i.rd(8'h28, rd_v);
    check({24'h00_0000, rd_v}, 32'h0000_0011);
    bst_host_model_i.rd(8'h29, rd_v);
    check({24'h00_0000, rd_v}, 32'h0000_000C);
    check({30'h0000_0000, offs}, 32'h0000_0003);
    bst_host_model_i.wr(8'h2A, 8'hFF);
    bst_host_model_i.rd(8'h2A, rd_v);
    check({24'h00_0000, rd_v}, 32'h0000_0000);
    bst_host_model_i.wr(8'h28, 8'hFF);
    check({7'h00, settle}, 32'h0000_0000);
    for (int c = 0; c < 16; c++) begin
      bst_host_model_i.wr(8'h28, {4'(c), 4'(15 - c)});
      pulse();
      check({7'h00, settle}, 32'(bst_pkg::LRA_US[c] * US));
      check({7'h00, disch}, 32'(bst_pkg::LRA_US[15 - c] * US));
    end
    erm = 1'b1;
    for (int c = 0; c < 8; c++) begin
      bst_host_model_i.wr(8'h28, {4'(c), 4'(c)});
      pulse();
      check({7'h00, settle}, 32'(bst_pkg::ERM_US[c % 4] * US));
      check({7'h00, disch}, 32'(bst_pkg::ERM_US[c % 4] * US));
      check({31'h0000_0000, undef}, 32'(c > 3));
    end
    erm = 1'b0;
    for (int w = 0; w < 4; w++) begin
      bst_host_model_i.wr(8'h29, {2'(w), 2'(w), 2'(3 - w), 2'(w)});
      bst_host_model_i.rd(8'h29, rd_v);
      check({24'h00_0000, rd_v}, 32'({2'(w), 2'(w), 2'(3 - w), 2'(w)}));
      pulse();
      check({7'h00, window}, 32'(bst_pkg::WIN_US[w] * US));
      check({30'h0000_0000, offs}, 32'(3 - w));
    end
    od = 1'b1;
    repeat (200) @(posedge CLOCK);
    #1;
    check({31'h0000_0000, clamp}, 32'h0000_0000);
    cal = 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    check({31'h0000_0000, clamp}, 32'h0000_0000);
    cal = 1'b0;
    diag = 1'b1;
    repeat (4) @(posedge CLOCK);
    #1;
    check({31'h0000_0000, clamp}, 32'h0000_0000);
    diag = 1'b0;
    od = 1'b0;
    results();
  end
endmodule : tb
`default_nettype wire
